//--- rtl/hio_device.sv
// Functional notes
// - Arbiter grants bus to one requester only
// - Granted process holds request until done
// - Backing-store decode: load args, drop done, set
// - Page carry increments backing-store address
// - Memory 256x256 words, via serial buffer
// - Pending transfer runs only on trigger
// - Board tri-states bus, triggers inside window
// - Address port loads block and column
// - Control port latches two-bit pending mode
// - Data port moves one word per operation
// - Host write sequence: pseudo, data, write
// - Host read sequence: read, wait, input
// - Strobe selects function from address lines
// - Status word bit layout
// - Live some/none needs handshake in software
//
// Purpose: Device end: port decode, buffer transfers, arbiter, backing store
// Assumes: Host keeps its own sequencing; trigger window covers 300 cycles
// Notes:   Serial buffer transfers one word per cycle after the trigger
`timescale 1ns/1ps
module hio_device
   import hio_pkg::*;
(
   input  wire logic              pclk,
   input  wire logic              presetn,
   hio_if.device                  bus,
   input  wire logic [1:0]        hold_req,
   output logic      [1:0]        hold_ack,
   input  wire logic              array_some_none,
   input  wire logic              memtest_error,
   input  wire logic              comparand,
   input  wire logic              chip_sel_row,
   input  wire logic              chip_sel_col,
   input  wire logic              bs_instr_valid,
   input  wire logic              bs_instr_write,
   input  wire logic [BS_AW-1:0]  bs_addr_in,
   input  wire logic [BS_FW-1:0]  bs_enable_in,
   input  wire logic [BS_FW-1:0]  bs_chipsel_in,
   input  wire logic [BS_FW-1:0]  bs_bank_in,
   input  wire logic              bs_page_carry,
   input  wire logic              bs_finish,
   output logic                   bstore_done,
   output logic                   bstore_rd_state,
   output logic                   bstore_wr_state,
   output logic      [BS_AW-1:0]  bstore_addr,
   output logic      [BS_FW-1:0]  bstore_enable,
   output logic      [BS_FW-1:0]  bstore_chipsel,
   output logic      [BS_FW-1:0]  bstore_bank,
   output logic                   xfer_busy
);
   typedef enum logic [1:0] {
      X_IDLE = 2'b00,
      X_RUN  = 2'b01,
      X_END  = 2'b11
   } xstate_t;

   logic [15:0]       shared_video_memory [BLOCKS*WORDS];
   logic [15:0]       serial_buf [WORDS];

   xstate_t           xst_q,    xst_d;
   mode_t             pending_mode_reg_q, pending_mode_reg_d;
   logic [7:0]        block_number_reg_q, block_number_reg_d;
   logic [7:0]        column_select_reg_q, column_select_reg_d;
   logic [7:0]        xcnt_q,   xcnt_d;
   logic              done_q,   done_d;
   logic [15:0]       rdata_q,  rdata_d;
   logic [1:0]        grant_q,  grant_d;
   logic              bs_done_q, bs_done_d;
   logic              bs_arm_q,  bs_arm_d;
   logic              bs_wr_q,   bs_wr_d;
   logic              bs_rd_st_q, bs_rd_st_d;
   logic              bs_wr_st_q, bs_wr_st_d;
   logic [BS_AW-1:0]  bs_addr_q, bs_addr_d;
   logic [BS_FW-1:0]  bs_en_q,   bs_en_d;
   logic [BS_FW-1:0]  bs_cs_q,   bs_cs_d;
   logic [BS_FW-1:0]  bs_bank_q, bs_bank_d;
   logic [ST_WIDTH-1:0] status_word;
   logic              wr_data, rd_data;
   logic [15:0]       mem_addr;

   assign wr_data  = bus.io_strobe && bus.io_write && (bus.io_addr == PORT_DATA);
   assign rd_data  = bus.io_strobe && !bus.io_write && (bus.io_addr == PORT_DATA);
   assign mem_addr = {block_number_reg_q, xcnt_q};

   always_comb begin
      status_word          = '0;
      status_word[ST_DONE] = done_q;
      status_word[ST_SN_A] = array_some_none;
      status_word[ST_BSTORE_DONE_BIT] = bs_done_q;
      status_word[ST_EF]   = memtest_error;
      status_word[ST_IC]   = comparand;
      status_word[ST_SN_B] = array_some_none;
      status_word[ST_ROW]  = chip_sel_row;
      status_word[ST_COL]  = chip_sel_col;
   end

   // Host port decode and buffer transfer sequencer
   always_comb begin
      xst_d               = xst_q;
      pending_mode_reg_d  = pending_mode_reg_q;
      block_number_reg_d  = block_number_reg_q;
      column_select_reg_d = column_select_reg_q;
      xcnt_d              = xcnt_q;
      done_d              = done_q;
      rdata_d             = rdata_q;
      if (bus.io_strobe && bus.io_write) begin
         case (bus.io_addr)
            PORT_ADDR: begin
               block_number_reg_d  = bus.io_wdata[BLK_HI:BLK_LO];
               column_select_reg_d = bus.io_wdata[COL_HI:0];
            end
            PORT_CTRL: begin
               pending_mode_reg_d = mode_t'(bus.io_wdata[1:0]);
               done_d             = (mode_t'(bus.io_wdata[1:0]) == MODE_NONE);
            end
            PORT_DATA: column_select_reg_d = column_select_reg_q + 8'h01;
            default: ;
         endcase
      end else if (bus.io_strobe) begin
         case (bus.io_addr)
            PORT_STATUS: rdata_d = {{(16-ST_WIDTH){1'b0}}, status_word};
            PORT_DATA: begin
               rdata_d             = serial_buf[column_select_reg_q];
               column_select_reg_d = column_select_reg_q + 8'h01;
            end
            default: rdata_d = '0;
         endcase
      end
      case (xst_q)
         X_IDLE: begin
            // Trigger only while the board has the memory bus released
            if (bus.transfer_trigger_in && bus.bus_released && pending_mode_reg_q != MODE_NONE) begin
               xcnt_d = '0;
               xst_d  = (pending_mode_reg_q == MODE_PSEUDO) ? X_END : X_RUN;
            end
         end
         X_RUN: begin
            xcnt_d = xcnt_q + 8'h01;
            if (xcnt_q == WORD_LAST) begin
               xst_d = X_END;
            end
         end
         X_END: begin
            done_d             = 1'b1;
            pending_mode_reg_d = MODE_NONE;
            xst_d              = X_IDLE;
         end
         default: xst_d = X_IDLE;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         xst_q               <= X_IDLE;
         pending_mode_reg_q  <= MODE_NONE;
         block_number_reg_q  <= '0;
         column_select_reg_q <= '0;
         xcnt_q              <= '0;
         done_q              <= 1'b0;
         rdata_q             <= '0;
      end else begin
         xst_q               <= xst_d;
         pending_mode_reg_q  <= pending_mode_reg_d;
         block_number_reg_q  <= block_number_reg_d;
         column_select_reg_q <= column_select_reg_d;
         xcnt_q              <= xcnt_d;
         done_q              <= done_d;
         rdata_q             <= rdata_d;
      end
   end

   // Memories have no reset; contents are undefined until written
   always_ff @(posedge pclk) begin
      if (xst_q == X_RUN && pending_mode_reg_q == MODE_READ) begin
         serial_buf[xcnt_q] <= shared_video_memory[mem_addr];
      end else if (wr_data) begin
         serial_buf[column_select_reg_q] <= bus.io_wdata;
      end
      if (xst_q == X_RUN && pending_mode_reg_q == MODE_WRITE) begin
         shared_video_memory[mem_addr] <= serial_buf[xcnt_q];
      end
   end

   // Hold arbiter and backing-store controller
   always_comb begin
      grant_d = grant_q;
      if ((grant_q & hold_req) == 2'b00) begin
         if (hold_req[0]) begin
            grant_d = 2'b01;
         end else if (hold_req[1]) begin
            grant_d = 2'b10;
         end else begin
            grant_d = 2'b00;
         end
      end
      bs_done_d  = bs_done_q;
      bs_arm_d   = 1'b0;
      bs_wr_d    = bs_wr_q;
      bs_rd_st_d = bs_rd_st_q;
      bs_wr_st_d = bs_wr_st_q;
      bs_addr_d  = bs_addr_q + {{(BS_AW-1){1'b0}}, bs_page_carry};
      bs_en_d    = bs_en_q;
      bs_cs_d    = bs_cs_q;
      bs_bank_d  = bs_bank_q;
      if (bs_arm_q) begin
         bs_rd_st_d = !bs_wr_q;
         bs_wr_st_d = bs_wr_q;
      end else if (bs_finish) begin
         bs_rd_st_d = 1'b0;
         bs_wr_st_d = 1'b0;
         bs_done_d  = 1'b1;
      end
      if (bs_instr_valid && !bs_arm_q && !bs_rd_st_q && !bs_wr_st_q) begin
         bs_addr_d = bs_addr_in;
         bs_en_d   = bs_enable_in;
         bs_cs_d   = bs_chipsel_in;
         bs_bank_d = bs_bank_in;
         bs_done_d = 1'b0;
         bs_wr_d   = bs_instr_write;
         bs_arm_d  = 1'b1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         grant_q    <= 2'b00;
         bs_done_q  <= 1'b1;
         bs_arm_q   <= 1'b0;
         bs_wr_q    <= 1'b0;
         bs_rd_st_q <= 1'b0;
         bs_wr_st_q <= 1'b0;
         bs_addr_q  <= '0;
         bs_en_q    <= '0;
         bs_cs_q    <= '0;
         bs_bank_q  <= '0;
      end else begin
         grant_q    <= grant_d;
         bs_done_q  <= bs_done_d;
         bs_arm_q   <= bs_arm_d;
         bs_wr_q    <= bs_wr_d;
         bs_rd_st_q <= bs_rd_st_d;
         bs_wr_st_q <= bs_wr_st_d;
         bs_addr_q  <= bs_addr_d;
         bs_en_q    <= bs_en_d;
         bs_cs_q    <= bs_cs_d;
         bs_bank_q  <= bs_bank_d;
      end
   end

   assign hold_ack            = grant_q;
   assign bus.io_rdata        = rdata_q;
   assign bus.host_wait_input = done_q;
   assign bstore_done         = bs_done_q;
   assign bstore_rd_state     = bs_rd_st_q;
   assign bstore_wr_state     = bs_wr_st_q;
   assign bstore_addr         = bs_addr_q;
   assign bstore_enable       = bs_en_q;
   assign bstore_chipsel      = bs_cs_q;
   assign bstore_bank         = bs_bank_q;
   assign xfer_busy           = (xst_q != X_IDLE);
endmodule : hio_device

//--- inc/hio_pkg.sv
// Purpose: Shared constants for the host I/O shared memory port
// Assumes: One clock, 16-bit host data, 4-bit host port address
// Notes:   Host APB offsets are byte addresses of 32-bit words
package hio_pkg;
   localparam logic [3:0]  PORT_STATUS = 4'h1;
   localparam logic [3:0]  PORT_DATA   = 4'hC;
   localparam logic [3:0]  PORT_CTRL   = 4'hD;
   localparam logic [3:0]  PORT_ADDR   = 4'hE;

   typedef enum logic [1:0] {
      MODE_NONE   = 2'h0,
      MODE_PSEUDO = 2'h1,
      MODE_WRITE  = 2'h2,
      MODE_READ   = 2'h3
   } mode_t;

   localparam int ST_DONE  = 0;
   localparam int ST_SN_A  = 3;
   localparam int ST_BSTORE_DONE_BIT  = 4;
   localparam int ST_EF    = 5;
   localparam int ST_IC    = 6;
   localparam int ST_SN_B  = 7;
   localparam int ST_ROW   = 8;
   localparam int ST_COL   = 9;
   localparam int ST_WIDTH = 10;

   localparam int          WORDS     = 256;
   localparam int          BLOCKS    = 256;
   localparam logic [7:0]  WORD_LAST = 8'hFF;
   localparam int          BLK_HI    = 15;
   localparam int          BLK_LO    = 8;
   localparam int          COL_HI    = 7;

   localparam int BS_AW = 16;
   localparam int BS_FW = 4;

   localparam logic [7:0]  REG_ADDR = 8'h00;
   localparam logic [7:0]  REG_CTRL = 8'h04;
   localparam logic [7:0]  REG_DATA = 8'h08;
   localparam logic [7:0]  REG_STAT = 8'h0C;
   localparam logic [7:0]  REG_WAIT = 8'h10;

   localparam logic [15:0] TRIG_PERIOD = 16'h0400;
   localparam logic [15:0] TRIG_WIN    = 16'h012C;
   localparam logic [15:0] TRIG_AT     = 16'h0001;
endpackage : hio_pkg

//--- inc/hio_if.sv
// Purpose: Host I/O port link between host end and device end
// Assumes: Both ends on pclk
// Notes:   io_strobe is a one-cycle pulse per host I/O operation
`timescale 1ns/1ps
interface hio_if;
   logic        io_strobe;
   logic [3:0]  io_addr;
   logic        io_write;
   logic [15:0] io_wdata;
   logic [15:0] io_rdata;
   logic        host_wait_input;
   logic        transfer_trigger_in;
   logic        bus_released;

   modport device (input io_strobe, io_addr, io_write, io_wdata, transfer_trigger_in, bus_released,
                   output io_rdata, host_wait_input);
   modport host   (output io_strobe, io_addr, io_write, io_wdata, transfer_trigger_in, bus_released,
                   input io_rdata, host_wait_input);
endinterface : hio_if

//--- rtl/hio_host.sv
// Purpose: Host end: APB registers turned into host I/O operations, plus board trigger
// Assumes: Software follows the write and read sequences, polling the wait register
// Notes:   One APB access to a port register is one host I/O operation; wait reads and errored accesses make none
`timescale 1ns/1ps
module hio_host
   import hio_pkg::*;
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   hio_if.host              bus
);
   typedef enum logic [1:0] {
      H_IDLE = 2'b00,
      H_STRB = 2'b01,
      H_RESP = 2'b11,
      H_DONE = 2'b10
   } hstate_t;

   hstate_t      st_q,     st_d;
   logic [3:0]   port_q,   port_d;
   logic         wr_q,     wr_d;
   logic [15:0]  wdata_q,  wdata_d;
   logic [31:0]  prdata_q, prdata_d;
   logic         err_q,    err_d;
   logic [15:0]  tcnt_q,   tcnt_d;
   logic         trig_q,   trig_d;
   logic         rel_q,    rel_d;
   logic         mapped;
   logic [3:0]   port_sel;

   always_comb begin
      mapped   = 1'b1;
      port_sel = PORT_STATUS;
      case (paddr)
         REG_ADDR: port_sel = PORT_ADDR;
         REG_CTRL: port_sel = PORT_CTRL;
         REG_DATA: port_sel = PORT_DATA;
         REG_STAT: port_sel = PORT_STATUS;
         default:  mapped   = 1'b0;
      endcase
   end

   always_comb begin
      st_d     = st_q;
      port_d   = port_q;
      wr_d     = wr_q;
      wdata_d  = wdata_q;
      prdata_d = prdata_q;
      err_d    = err_q;
      case (st_q)
         H_IDLE: begin
            if (psel && !penable) begin
               err_d    = 1'b0;
               prdata_d = '0;
               if (paddr == REG_WAIT) begin
                  prdata_d = {31'h0, bus.host_wait_input};
                  st_d     = H_DONE;
               end else if (!mapped || (pwrite && paddr == REG_STAT)) begin
                  err_d = 1'b1;
                  st_d  = H_DONE;
               end else begin
                  port_d  = port_sel;
                  wr_d    = pwrite;
                  wdata_d = pwdata[15:0];
                  st_d    = H_STRB;
               end
            end
         end
         H_STRB: st_d = H_RESP;
         H_RESP: begin
            prdata_d = wr_q ? 32'h0 : {16'h0, bus.io_rdata};
            st_d     = H_DONE;
         end
         H_DONE: begin
            if (psel && penable) begin
               st_d = H_IDLE;
            end
         end
         default: st_d = H_IDLE;
      endcase
   end

   // Board refresh window and trigger inside it
   always_comb begin
      tcnt_d = (tcnt_q == TRIG_PERIOD) ? 16'h0 : tcnt_q + 16'h1;
      rel_d  = (tcnt_d < TRIG_WIN);
      trig_d = (tcnt_d == TRIG_AT);
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_q     <= H_IDLE;
         port_q   <= PORT_STATUS;
         wr_q     <= 1'b0;
         wdata_q  <= '0;
         prdata_q <= '0;
         err_q    <= 1'b0;
         tcnt_q   <= '0;
         trig_q   <= 1'b0;
         rel_q    <= 1'b0;
      end else begin
         st_q     <= st_d;
         port_q   <= port_d;
         wr_q     <= wr_d;
         wdata_q  <= wdata_d;
         prdata_q <= prdata_d;
         err_q    <= err_d;
         tcnt_q   <= tcnt_d;
         trig_q   <= trig_d;
         rel_q    <= rel_d;
      end
   end

   assign bus.io_strobe           = (st_q == H_STRB);
   assign bus.io_addr             = port_q;
   assign bus.io_write            = wr_q;
   assign bus.io_wdata            = wdata_q;
   assign bus.transfer_trigger_in = trig_q;
   assign bus.bus_released        = rel_q;
   assign prdata                  = prdata_q;
   assign pready                  = (st_q == H_DONE);
   assign pslverr                 = (st_q == H_DONE) && err_q;
endmodule : hio_host

//--- tb/hio_chk.sv
// Purpose: Link-level checks between host end and device end
// Assumes: Single pclk domain, async active-low reset
// Notes:   Pending mode is tracked from control writes seen on the link
`timescale 1ns/1ps
module hio_chk
   import hio_pkg::*;
(
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        io_strobe,
   input wire logic [3:0]  io_addr,
   input wire logic        io_write,
   input wire logic [15:0] io_wdata,
   input wire logic [15:0] io_rdata,
   input wire logic        host_wait_input,
   input wire logic        transfer_trigger_in,
   input wire logic        bus_released
);
   mode_t mode_q;
   mode_t mode_d;
   logic  ctrl_wr;
   logic  quiet_trig;

   assign ctrl_wr    = io_strobe && io_write && (io_addr == PORT_CTRL);
   assign quiet_trig = transfer_trigger_in && !io_strobe;

   always_comb begin
      mode_d = mode_q;
      if (ctrl_wr) mode_d = mode_t'(io_wdata[1:0]);
      else if (transfer_trigger_in) mode_d = MODE_NONE;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) mode_q <= MODE_NONE;
      else mode_q <= mode_d;
   end

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   strobe_pulse_a: assert property (io_strobe |=> !io_strobe)
      else $error("io strobe longer than one cycle");
   trig_pulse_a: assert property (transfer_trigger_in |=> !transfer_trigger_in)
      else $error("trigger longer than one cycle");
   trig_released_a: assert property (transfer_trigger_in |-> bus_released)
      else $error("trigger while bus not released");
   ctrl_clear_a: assert property (ctrl_wr && io_wdata[1:0] != 2'h0 |=> !host_wait_input)
      else $error("wait input not cleared by control write");
   ctrl_none_a: assert property (ctrl_wr && io_wdata[1:0] == 2'h0 |=> host_wait_input)
      else $error("idle mode did not raise wait input");
   pseudo_done_a: assert property (quiet_trig && mode_q == MODE_PSEUDO
      |-> ##1 !host_wait_input ##1 host_wait_input)
      else $error("pseudo write completion timing wrong");
   copy_done_a: assert property (quiet_trig && mode_q inside {MODE_WRITE, MODE_READ}
      |-> ##257 !host_wait_input ##1 host_wait_input)
      else $error("block copy completion timing wrong");
   idle_trig_a: assert property (quiet_trig && mode_q == MODE_NONE && host_wait_input |=> host_wait_input)
      else $error("trigger without pending mode changed wait input");
   pend_hold_a: assert property (mode_q != MODE_NONE && !host_wait_input && !transfer_trigger_in && !io_strobe
      |=> !host_wait_input)
      else $error("pending transfer completed without trigger");
   stat_spare_a: assert property (io_strobe && !io_write && io_addr == PORT_STATUS |=> io_rdata[2:1] == 2'h0)
      else $error("status spare bits not zero");
endmodule : hio_chk

//--- tb/host_io_shared_memory_port_bench.sv
// Purpose: Self-checking bench, host end and device end joined by the link
// Assumes: APB drives the host end; bench drives the device side inputs
// Notes:   Shared memory and serial buffer are modelled to predict reads
`timescale 1ns/1ps
module host_io_shared_memory_port_bench;
   import hio_pkg::*;
   logic             pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [7:0]       paddr;
   logic [31:0]      pwdata, prdata;
   logic [1:0]       hold_req, hold_ack, ack_e;
   logic             sn, ef, ic, row, col, bs_v, bs_w, bs_carry, bs_fin;
   logic [BS_AW-1:0] bs_a, bs_ao;
   logic [BS_FW-1:0] bs_e, bs_c, bs_b, bs_eo, bs_co, bs_bo;
   logic             bs_done, bs_rd, bs_wr, busy;
   logic [15:0]      sb [WORDS];
   logic [15:0]      mem [BLOCKS][WORDS];
   logic [7:0]       blk;
   int               miscompares, n_tests, cycles, n_strobe, n_busy;

   hio_if link();
   hio_host hio_host_i(.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .bus(link));
   hio_device hio_device_i(.pclk(pclk), .presetn(presetn), .bus(link), .hold_req(hold_req), .hold_ack(hold_ack),
      .array_some_none(sn), .memtest_error(ef), .comparand(ic), .chip_sel_row(row), .chip_sel_col(col),
      .bs_instr_valid(bs_v), .bs_instr_write(bs_w), .bs_addr_in(bs_a), .bs_enable_in(bs_e),
      .bs_chipsel_in(bs_c), .bs_bank_in(bs_b), .bs_page_carry(bs_carry), .bs_finish(bs_fin),
      .bstore_done(bs_done), .bstore_rd_state(bs_rd), .bstore_wr_state(bs_wr), .bstore_addr(bs_ao),
      .bstore_enable(bs_eo), .bstore_chipsel(bs_co), .bstore_bank(bs_bo), .xfer_busy(busy));
   hio_chk hio_chk_i(.pclk(pclk), .presetn(presetn), .io_strobe(link.io_strobe), .io_addr(link.io_addr),
      .io_write(link.io_write), .io_wdata(link.io_wdata), .io_rdata(link.io_rdata),
      .host_wait_input(link.host_wait_input), .transfer_trigger_in(link.transfer_trigger_in),
      .bus_released(link.bus_released));

   always #10 pclk = ~pclk;

   // Hang guard: longest path is a few block copies plus trigger waits
   always @(posedge pclk) begin
      cycles++;
      if (link.io_strobe && link.io_addr == PORT_DATA) n_strobe++;
      if (busy) n_busy++;
      if (cycles == 60000) begin
         miscompares++;
         finish_test();
      end
   end

   task automatic finish_test;
      $display("miscompares %0d n_tests %0d", miscompares, n_tests);
      if (miscompares == 0 && n_tests > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : finish_test

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         miscompares++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
      @(posedge pclk);
      psel    <= 1'h1;
      penable <= 1'h0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'h1;
      do @(posedge pclk); while (pready !== 1'h1);
      r = prdata;
      e = pslverr;
      psel    <= 1'h0;
      penable <= 1'h0;
   endtask : apb

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic        e;
      apb(1'h1, a, d, r, e);
      chk(e, 0);
   endtask : wr

   task automatic rd(input logic [7:0] a, output logic [31:0] r);
      logic e;
      apb(1'h0, a, 32'h0, r, e);
      chk(e, 0);
   endtask : rd

   // Issue a mode and wait for the trigger-driven completion
   task automatic run_mode(input mode_t m);
      logic [31:0] r;
      int          b0;
      b0 = n_busy;
      wr(REG_CTRL, {30'h0, m});
      do rd(REG_WAIT, r); while (r[0] !== 1'h1);
      // Busy spans the 256 word copies plus the closing cycle
      chk(n_busy - b0, (m == MODE_NONE) ? 0 : (m == MODE_PSEUDO) ? 1 : WORDS + 1);
      chk(busy, 0);
   endtask : run_mode

   task automatic put(input logic [7:0] b, input logic [7:0] c, input int n);
      logic [15:0] w;
      int          s0;
      wr(REG_ADDR, {16'h0, b, c});
      run_mode(MODE_PSEUDO);
      s0 = n_strobe;
      for (int i = 0; i < n; i++) begin
         w = 16'($urandom);
         wr(REG_DATA, {16'h0, w});
         sb[c] = w;
         c++;
      end
      chk(n_strobe - s0, n);
      run_mode(MODE_WRITE);
      for (int i = 0; i < WORDS; i++) mem[b][i] = sb[i];
   endtask : put

   task automatic get(input logic [7:0] b, input logic [7:0] c, input int n);
      logic [31:0] r;
      wr(REG_ADDR, {16'h0, b, c});
      run_mode(MODE_READ);
      for (int i = 0; i < WORDS; i++) sb[i] = mem[b][i];
      for (int i = 0; i < n; i++) begin
         rd(REG_DATA, r);
         chk(r[15:0], sb[c]);
         c++;
      end
   endtask : get

   function automatic logic [9:0] stat_exp(input logic bsd, input logic dn);
      logic [9:0] s;
      s = 10'h0;
      s[ST_DONE] = dn;
      s[ST_SN_A] = sn;
      s[ST_SN_B] = sn;
      s[ST_BSTORE_DONE_BIT] = bsd;
      s[ST_EF]   = ef;
      s[ST_IC]   = ic;
      s[ST_ROW]  = row;
      s[ST_COL]  = col;
      return s;
   endfunction : stat_exp

   task automatic stat_check(input logic bsd, input logic dn);
      logic [31:0] r;
      rd(REG_STAT, r);
      chk(r, {22'h0, stat_exp(bsd, dn)});
   endtask : stat_check

   // Settled grant: held grant kept, requester 0 wins ties
   function automatic logic [1:0] next_ack(input logic [1:0] prev, input logic [1:0] req);
      if ((prev & req) != 2'h0) return prev;
      if (req[0]) return 2'h1;
      if (req[1]) return 2'h2;
      return 2'h0;
   endfunction : next_ack

   initial begin
      logic [31:0] r;
      logic        e;
      pclk = 1'h0;
      presetn = 1'h0;
      psel = 1'h0;
      penable = 1'h0;
      pwrite = 1'h0;
      paddr = 8'h0;
      pwdata = 32'h0;
      hold_req = 2'h0;
      {sn, ef, ic, row, col} = 5'h0;
      {bs_v, bs_w, bs_carry, bs_fin} = 4'h0;
      bs_a = '0;
      bs_e = '0;
      bs_c = '0;
      bs_b = '0;
      void'($urandom(66247));
      repeat (4) @(posedge pclk);
      presetn <= 1'h1;
      rd(REG_WAIT, r);
      chk(r[0], 0);
      chk({bs_done, hold_ack}, 3'h4);
      repeat (4) begin
         @(posedge pclk);
         // Held steady across the read, standing in for the array handshake
         {sn, ef, ic, row, col} <= 5'($urandom);
         stat_check(1'h1, 1'h0);
      end
      apb(1'h1, REG_STAT, 32'h3FF, r, e);
      chk(e, 1);
      apb(1'h0, 8'h14, 32'h0, r, e);
      chk(e, 1);
      run_mode(MODE_NONE);
      ack_e = 2'h0;
      // Walk the arbiter through hold under contention, release and re-grant, then random requests
      for (int i = 0; i < 24; i++) begin
         @(posedge pclk);
         hold_req <= (i < 6) ? 2'(32'h2D3D >> (2 * i)) : 2'($urandom);
         repeat (4) @(posedge pclk);
         ack_e = next_ack(ack_e, hold_req);
         chk(hold_ack, ack_e);
      end
      for (int i = 0; i < 2; i++) begin
         @(posedge pclk);
         bs_v <= 1'h1;
         bs_w <= i[0];
         bs_a <= (i == 0) ? 16'hFFFF : 16'($urandom);
         {bs_e, bs_c, bs_b} <= 12'($urandom);
         @(posedge pclk);
         bs_v <= 1'h0;
         repeat (3) @(posedge pclk);
         chk({bs_done, bs_wr, bs_rd}, {1'h0, i[0], !i[0]});
         chk({bs_ao, bs_eo, bs_co, bs_bo}, {bs_a, bs_e, bs_c, bs_b});
         stat_check(1'h0, 1'h1);
         bs_carry <= 1'h1;
         @(posedge pclk);
         bs_carry <= 1'h0;
         repeat (3) @(posedge pclk);
         chk(bs_ao, 16'(bs_a + 16'h1));
         bs_fin <= 1'h1;
         @(posedge pclk);
         bs_fin <= 1'h0;
         repeat (3) @(posedge pclk);
         chk({bs_done, bs_wr, bs_rd}, 3'h4);
      end
      blk = 8'($urandom);
      put(blk, 8'($urandom), WORDS);
      get(blk, 8'($urandom), WORDS);
      put(~blk, WORD_LAST, 16);
      get(~blk, 8'hF8, 32);
      get(blk, 8'h0, 8);
      finish_test();
   end
endmodule : host_io_shared_memory_port_bench
